// ---- include/isp_pkg.sv ----
// shared constants and state type of the two-wire register write port
// assumes a link clock of 125 ns and a system clock of 40 ns

package isp_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int LINK_CLK_KHZ = 8000;
   localparam int FAST_MODE_KBPS = 400;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_RAW = (SPIKE_NS * LINK_CLK_KHZ + 999999) / 1000000;
   localparam int SPIKE_CYC = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;
   localparam int STRAP_SETTLE = 3;

   // ----------------------------------------------------------------
   // addressing and framing
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_BASE_DEFINED = 5'h14;
   localparam logic [4:0] ADDR_BASE_ONE_FLOAT = 5'h15;
   localparam logic [6:0] ADDR_BOTH_FLOAT = 7'h58;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int CMD_SEL_W = 6;
   localparam int REG_W = 8;
   localparam logic [63:0] REG_VALID_DEF = 64'h0000_0000_0000_00FF;
   localparam logic [7:0] TX_RESET_VAL = 8'hFF;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h3,
      ST_CMD = 4'h2,
      ST_CACK = 4'h6,
      ST_DATA = 4'h7,
      ST_DACK = 4'h5,
      ST_TX = 4'h4,
      ST_TACK = 4'hC,
      ST_IGNORE = 4'hD
   } isp_state_type;

endpackage

// ---- core/isp_sync.sv ----
// three-stage synchroniser with agreement and hold filter
// assumes din is asynchronous to clk; rst is asynchronous, active high
`timescale 1ns/100ps
`default_nettype none

module isp_sync #(
   parameter int FILT = 1,
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and filtered level out
   input wire logic din,
   output logic dout
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic [3:0] cnt_q;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // new level taken once stages two and three agree for FILT cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout <= RST_VAL;
         cnt_q <= 4'h0;
      end else if (s2_q == s3_q && s3_q != dout) begin
         if (cnt_q == 4'(FILT - 1)) begin
            dout <= s3_q;
            cnt_q <= 4'h0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end else begin
         cnt_q <= 4'h0;
      end
   end

endmodule

`default_nettype wire

// ---- core/isp_port.sv ----
// two-wire slave port that turns bus writes into register write strobes
// assumes scl/sda pins are async to link_clk; straps static after reset
`timescale 1ns/100ps
`default_nettype none

module isp_port #(
   parameter logic [63:0] REG_VALID_MAP = isp_pkg::REG_VALID_DEF
) (
   // system clock domain
   input wire logic clock,
   input wire logic rst,
   // link clock domain
   input wire logic link_clk,
   // bus pins, scl is input only
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // address straps, level plus floating flag
   input wire logic addr_strap_high,
   input wire logic addr_strap_high_float,
   input wire logic addr_strap_low,
   input wire logic addr_strap_low_float,
   // register write side, system clock
   output logic reg_wr,
   output logic [isp_pkg::CMD_SEL_W-1:0] reg_addr,
   output logic [isp_pkg::REG_W-1:0] reg_data,
   output logic bus_busy
);

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic scl_f;
   logic sda_f;
   logic scl_prev_q;
   logic sda_prev_q;

   // scl is only ever sampled, never driven or held
   // filter length keeps a fast-mode high phase intact
   isp_sync #(.FILT(isp_pkg::SPIKE_CYC), .RST_VAL(1'b1)) u_scl_sync (
      .clk(link_clk),
      .rst(rst),
      .din(scl_in),
      .dout(scl_f)
   );

   isp_sync #(.FILT(isp_pkg::SPIKE_CYC), .RST_VAL(1'b1)) u_sda_sync (
      .clk(link_clk),
      .rst(rst),
      .din(sda_in),
      .dout(sda_f)
   );

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise = scl_f && !scl_prev_q;
   assign scl_fall = !scl_f && scl_prev_q;
   // sda moving with scl high is a control condition
   assign start_det = scl_f && scl_prev_q && sda_prev_q && !sda_f;
   assign stop_det = scl_f && scl_prev_q && !sda_prev_q && sda_f;

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   logic [3:0] strap_p1_q;
   logic [3:0] strap_p2_q;
   logic [1:0] strap_cnt_q;
   logic strap_done_q;
   logic [6:0] dev_addr_q;

   function automatic logic [6:0] strap_addr(input logic [3:0] s);
      logic hi;
      logic hf;
      logic lo;
      logic lf;
      hi = s[3];
      hf = s[2];
      lo = s[1];
      lf = s[0];
      if (!hf && !lf) begin
         strap_addr = {isp_pkg::ADDR_BASE_DEFINED, hi, lo};
      end else if (hf && lf) begin
         strap_addr = isp_pkg::ADDR_BOTH_FLOAT;
      end else begin
         // level of the driven pin, then which pin floats
         strap_addr = {isp_pkg::ADDR_BASE_ONE_FLOAT, hf ? lo : hi, hf};
      end
   endfunction

   // straps caught a few cycles after release, never at reset
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         strap_p1_q <= 4'h0;
         strap_p2_q <= 4'h0;
         strap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
         dev_addr_q <= 7'h00;
      end else begin
         strap_p1_q <= {addr_strap_high, addr_strap_high_float,
                        addr_strap_low, addr_strap_low_float};
         strap_p2_q <= strap_p1_q;
         if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'(isp_pkg::STRAP_SETTLE)) begin
               strap_done_q <= 1'b1;
               dev_addr_q <= strap_addr(strap_p2_q);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   isp_pkg::isp_state_type state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] tx_q;
   logic sda_oe_n_q;
   logic sda_out_q;
   logic busy_q;
   logic [isp_pkg::CMD_SEL_W-1:0] sel_q;
   logic [isp_pkg::CMD_SEL_W-1:0] wr_addr_q;
   logic [isp_pkg::REG_W-1:0] wr_data_q;
   logic wr_tog_q;
   logic byte_done;

   assign byte_done = scl_fall && bit_cnt_q == isp_pkg::BITS_PER_BYTE;

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else if (start_det) begin
         busy_q <= 1'b1;
      end else if (stop_det) begin
         busy_q <= 1'b0;
      end
   end

   // receive shift and bit count
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
      end else if (start_det || stop_det) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_rise) begin
         shift_q <= {shift_q[6:0], sda_f};
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_fall && state_q inside {isp_pkg::ST_AACK,
               isp_pkg::ST_CACK, isp_pkg::ST_DACK, isp_pkg::ST_TACK}) begin
         bit_cnt_q <= 4'h0;
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         state_q <= isp_pkg::ST_IDLE;
         sda_oe_n_q <= 1'b1;
         sel_q <= '0;
         tx_q <= isp_pkg::TX_RESET_VAL;
      end else if (start_det) begin
         state_q <= isp_pkg::ST_ADDR;
         sda_oe_n_q <= 1'b1;
      end else if (stop_det) begin
         state_q <= isp_pkg::ST_IDLE;
         sda_oe_n_q <= 1'b1;
      end else begin
         unique case (state_q)
            isp_pkg::ST_IDLE, isp_pkg::ST_IGNORE: begin
               sda_oe_n_q <= 1'b1;
            end
            isp_pkg::ST_ADDR: begin
               if (byte_done) begin
                  if (shift_q[7:1] == dev_addr_q) begin
                     state_q <= isp_pkg::ST_AACK;
                     sda_oe_n_q <= 1'b0;
                  end else begin
                     state_q <= isp_pkg::ST_IGNORE;
                  end
               end
            end
            isp_pkg::ST_AACK: begin
               if (scl_fall) begin
                  // ack bit has shifted in behind the direction bit
                  if (shift_q[1]) begin
                     state_q <= isp_pkg::ST_TX;
                     tx_q <= wr_data_q;
                     sda_oe_n_q <= wr_data_q[7];
                  end else begin
                     state_q <= isp_pkg::ST_CMD;
                     sda_oe_n_q <= 1'b1;
                  end
               end
            end
            isp_pkg::ST_CMD: begin
               if (byte_done) begin
                  if (REG_VALID_MAP[shift_q[5:0]]) begin
                     sel_q <= shift_q[5:0];
                     state_q <= isp_pkg::ST_CACK;
                     sda_oe_n_q <= 1'b0;
                  end else begin
                     state_q <= isp_pkg::ST_IGNORE;
                  end
               end
            end
            isp_pkg::ST_CACK, isp_pkg::ST_DACK: begin
               // more data bytes may follow without limit
               if (scl_fall) begin
                  state_q <= isp_pkg::ST_DATA;
                  sda_oe_n_q <= 1'b1;
               end
            end
            isp_pkg::ST_DATA: begin
               if (byte_done) begin
                  state_q <= isp_pkg::ST_DACK;
                  sda_oe_n_q <= 1'b0;
               end
            end
            isp_pkg::ST_TX: begin
               if (byte_done) begin
                  state_q <= isp_pkg::ST_TACK;
                  sda_oe_n_q <= 1'b1;
               end else if (scl_fall) begin
                  tx_q <= {tx_q[6:0], 1'b1};
                  sda_oe_n_q <= tx_q[6];
               end
            end
            isp_pkg::ST_TACK: begin
               if (scl_fall) begin
                  if (shift_q[0]) begin
                     state_q <= isp_pkg::ST_IGNORE;
                     sda_oe_n_q <= 1'b1;
                  end else begin
                     state_q <= isp_pkg::ST_TX;
                     tx_q <= wr_data_q;
                     sda_oe_n_q <= wr_data_q[7];
                  end
               end
            end
            default: begin
               state_q <= isp_pkg::ST_IDLE;
               sda_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // only ever pulls low, so the driven level is a constant zero
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= 1'b0;
      end
   end

   // write captured at the data acknowledge; held until the next one
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         wr_addr_q <= '0;
         wr_data_q <= isp_pkg::TX_RESET_VAL;
         wr_tog_q <= 1'b0;
      end else if (state_q == isp_pkg::ST_DATA && byte_done && !start_det
                   && !stop_det) begin
         wr_addr_q <= sel_q;
         wr_data_q <= shift_q;
         wr_tog_q <= ~wr_tog_q;
      end
   end

   assign sda_oe_n = sda_oe_n_q;
   assign sda_out = sda_out_q;

   // ----------------------------------------------------------------
   // crossing to the system clock
   // ----------------------------------------------------------------
   logic tog_s;
   logic seen_q;

   // address and data words are stable for a whole byte time, far
   // longer than the toggle takes to cross
   isp_sync #(.FILT(1), .RST_VAL(1'b0)) u_tog_sync (
      .clk(clock),
      .rst(rst),
      .din(wr_tog_q),
      .dout(tog_s)
   );

   isp_sync #(.FILT(1), .RST_VAL(1'b0)) u_busy_sync (
      .clk(clock),
      .rst(rst),
      .din(busy_q),
      .dout(bus_busy)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         seen_q <= 1'b0;
         reg_wr <= 1'b0;
         reg_addr <= '0;
         reg_data <= '0;
      end else begin
         seen_q <= tog_s;
         reg_wr <= tog_s != seen_q;
         if (tog_s != seen_q) begin
            reg_addr <= wr_addr_q;
            reg_data <= wr_data_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (rst);

   a_start_to_addr: assert property (start_det |=> state_q == isp_pkg::ST_ADDR)
      else $error("start did not enter address phase");
   a_stop_to_idle: assert property (stop_det |=> state_q == isp_pkg::ST_IDLE && sda_oe_n_q)
      else $error("stop did not return to idle");
   a_busy_until_stop: assert property (busy_q && !stop_det |=> busy_q)
      else $error("bus freed without stop");
   a_drive_scl_low: assert property ($fell(sda_oe_n_q) |-> !$past(scl_f))
      else $error("sda pulled while scl high");
   a_addr_mismatch: assert property (state_q == isp_pkg::ST_ADDR && byte_done && !start_det && !stop_det && shift_q[7:1] != dev_addr_q |=> state_q == isp_pkg::ST_IGNORE && sda_oe_n_q)
      else $error("answered a foreign address");
   a_cmd_reject: assert property (state_q == isp_pkg::ST_CMD && byte_done && !start_det && !stop_det && !REG_VALID_MAP[shift_q[5:0]] |=> sda_oe_n_q [*2])
      else $error("acknowledged a missing register");
   a_data_ack_low: assert property (state_q == isp_pkg::ST_DACK && scl_f |-> !sda_oe_n_q)
      else $error("data acknowledge not held low");
   a_write_capture: assert property (state_q == isp_pkg::ST_DATA && byte_done && !start_det && !stop_det |=> $changed(wr_tog_q) && wr_data_q == $past(shift_q))
      else $error("write not captured at acknowledge");
   a_nack_release: assert property (state_q == isp_pkg::ST_TACK && scl_fall && shift_q[0] && !start_det && !stop_det |=> sda_oe_n_q && state_q == isp_pkg::ST_IGNORE)
      else $error("sda not released after nack");
   a_strap_range: assert property (strap_done_q |-> dev_addr_q[6:4] == 3'h5 && dev_addr_q <= isp_pkg::ADDR_BOTH_FLOAT)
      else $error("strapped address out of range");
   a_wr_single: assert property (@(posedge clock) reg_wr |=> !reg_wr)
      else $error("write strobe longer than one cycle");

   c_single_write: cover property (state_q == isp_pkg::ST_DACK);
   c_read_tx: cover property (state_q == isp_pkg::ST_TX);
   c_cmd_reject: cover property (state_q == isp_pkg::ST_CMD ##1 state_q == isp_pkg::ST_IGNORE);
   c_restart: cover property (start_det && busy_q);

endmodule

`default_nettype wire

// ---- bench/isp_master.sv ----
// behavioural two-wire bus master used as far side of the port
// assumes a pull-up on SDA, wire level resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module isp_master (
   // clock
   input wire logic clock,
   // bus
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // ----------------------------------------------------------------
   // bit timing, 64 clocks a bit keeps us under fast mode
   // ----------------------------------------------------------------
   localparam int QTR = 16;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic qp();
      repeat (QTR) @(negedge clock);
   endtask

   // ----------------------------------------------------------------
   // bus primitives
   // ----------------------------------------------------------------
   // sda moves only mid low phase; sample ored so ack must hold
   task automatic bit_io(input logic b, output logic smp);
      logic mid;
      qp();
      sda_low = ~b;
      qp();
      scl = 1'b1;
      qp();
      mid = sda;
      qp();
      smp = mid | sda;
      scl = 1'b0;
   endtask

   task automatic start();
      qp();
      sda_low = 1'b0;
      qp();
      scl = 1'b1;
      qp();
      qp();
      sda_low = 1'b1;
      qp();
      scl = 1'b0;
   endtask

   task automatic stop();
      qp();
      sda_low = 1'b1;
      qp();
      scl = 1'b1;
      qp();
      qp();
      sda_low = 1'b0;
      qp();
      qp();
   endtask

   // msb first, ninth clock with sda released
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, ack);
   endtask

   task automatic read_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule
`default_nettype wire

// ---- bench/test_isp_port.sv ----
// self-checking bench of the two-wire register write port
// assumes isp_master as bus master and default register map 0..7
`timescale 1ns/100ps
`default_nettype none

module test_isp_port;
   logic clock, link_clk, rst, scl, sda_w, sda_out, sda_oe_n;
   logic [3:0] st;
   logic reg_wr, bus_busy;
   logic [5:0] reg_addr;
   logic [7:0] reg_data;
   int miscompares = 0;
   int n_compared = 0;
   int n_wr = 0;

   // ----------------------------------------------------------------
   // clocks, wire and instances
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      link_clk = 1'b0;
      #17;
      forever #62.5 link_clk = ~link_clk;
   end
   assign sda_w = (m.sda_low === 1'b1) ? 1'b0 :
                  (sda_oe_n === 1'b0) ? sda_out : 1'b1;
   always @(posedge clock) if (reg_wr === 1'b1) n_wr <= n_wr + 1;

   isp_master m (.clock(clock), .sda(sda_w), .scl(scl), .sda_low());
   isp_port uut (.clock(clock), .rst(rst), .link_clk(link_clk),
      .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_strap_high(st[2]),
      .addr_strap_high_float(st[3]), .addr_strap_low(st[0]),
      .addr_strap_low_float(st[1]), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_data(reg_data), .bus_busy(bus_busy));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic do_reset(input logic [3:0] s);
      @(negedge clock);
      st = s;
      rst = 1'b1;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      repeat (50) @(negedge clock);
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 100 && bus_busy !== 1'b0; i++) @(negedge clock);
      if (i == 100) begin
         miscompares++;
         end_of_test();
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_addr();
      // strap code for address 0x50+i sits in nibble i
      logic [35:0] tab = 36'hA96825410;
      logic a;
      for (int i = 0; i < 9; i++) begin
         do_reset(tab[4*i +: 4]);
         m.start();
         m.write_byte({7'h50 + 7'(i), 1'b0}, a);
         chk("addr_ack", a, 8'h00);
         m.stop();
         m.start();
         m.write_byte({7'h50 + 7'((i + 1) % 9), 1'b0}, a);
         chk("other_nack", a, 8'h01);
         m.stop();
      end
      $display("test addr done");
   endtask

   task automatic t_write();
      logic a;
      int n0;
      n0 = n_wr;
      m.start();
      m.write_byte(8'hA0, a);
      chk("busy", bus_busy, 8'h01);
      m.write_byte(8'hC2, a);
      chk("cmd_ack", a, 8'h00);
      chk("no_early_wr", n_wr - n0, 8'h00);
      m.write_byte(8'hA5, a);
      chk("data_ack", a, 8'h00);
      chk("wr_count", n_wr - n0, 8'h01);
      chk("reg_addr", reg_addr, 8'h02);
      chk("reg_data", reg_data, 8'hA5);
      m.stop();
      wait_idle();
      $display("test write done");
   endtask

   task automatic t_chain();
      logic a;
      int n0;
      n0 = n_wr;
      m.start();
      m.write_byte(8'hA0, a);
      m.write_byte(8'h01, a);
      m.write_byte(8'h3C, a);
      chk("reg_addr", reg_addr, 8'h01);
      chk("reg_data", reg_data, 8'h3C);
      m.start();
      chk("busy_rs", bus_busy, 8'h01);
      m.write_byte(8'hA0, a);
      chk("rs_ack", a, 8'h00);
      m.write_byte(8'h07, a);
      m.write_byte(8'h81, a);
      chk("reg_data", reg_data, 8'h81);
      m.write_byte(8'h7E, a);
      chk("extra_ack", a, 8'h00);
      chk("reg_addr", reg_addr, 8'h07);
      chk("reg_data", reg_data, 8'h7E);
      chk("wr_count", n_wr - n0, 8'h03);
      m.stop();
      wait_idle();
      $display("test chain done");
   endtask

   task automatic t_bad();
      logic a;
      int n0;
      n0 = n_wr;
      m.start();
      m.write_byte(8'hA0, a);
      m.write_byte(8'h08, a);
      chk("bad_cmd", a, 8'h01);
      m.write_byte(8'h55, a);
      chk("ignored", a, 8'h01);
      m.stop();
      m.start();
      m.write_byte(8'hA0, a);
      m.write_byte(8'h3F, a);
      chk("bad_top", a, 8'h01);
      m.stop();
      chk("wr_count", n_wr - n0, 8'h00);
      $display("test bad done");
   endtask

   task automatic t_read();
      logic a;
      logic [7:0] d;
      m.start();
      m.write_byte(8'hA1, a);
      chk("rd_ack", a, 8'h00);
      m.read_byte(1'b0, d);
      chk("rd_data", d, 8'h7E);
      m.read_byte(1'b1, d);
      chk("rd_again", d, 8'h7E);
      repeat (8) @(negedge clock);
      chk("released", sda_oe_n, 8'h01);
      m.stop();
      wait_idle();
      $display("test read done");
   endtask

   task automatic t_glitch();
      @(negedge clock);
      m.sda_low = 1'b1;
      @(negedge clock);
      m.sda_low = 1'b0;
      repeat (20) @(negedge clock);
      chk("glitch_busy", bus_busy, 8'h00);
      $display("test glitch done");
   endtask

   initial begin
      rst = 1'b1;
      st = 4'h0;
      t_addr();
      do_reset(4'h0);
      t_glitch();
      t_write();
      t_chain();
      t_bad();
      t_read();
      end_of_test();
   end
endmodule
`default_nettype wire
